// ---- inc/bbfc_pkg.sv ----
// Purpose: Shared constants and types of the boot-block flash controller.
// Assumes: 20 MHz aclk, 8-bit AXI4-Lite byte addresses.
// Notes: Pin timing figures are conservative host-side values.
package bbfc_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 50;
  localparam int T_WE_NS = 100;   // Write strobe low time
  localparam int T_ACC_NS = 150;  // Read access time before sampling
  localparam int T_REC_NS = 50;   // Strobes high between cycles
  localparam logic [3:0] WE_CYC = 4'((T_WE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] ACC_CYC = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS + 2);
  localparam logic [3:0] REC_CYC = 4'((T_REC_NS + CLK_NS - 1) / CLK_NS);

  // ---------------------------------------------------------------
  // Flash command codes, status bits, boot decode
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_A = 8'hD0;
  localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
  localparam logic [7:0] CMD_WRITE_SETUP_ALT = 8'h10;
  localparam logic [7:0] IDENTIFY_CMD = 8'h90;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam int SR_READY = 7;
  localparam int SR_SUSP = 6;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_WRITE_ERR = 4;
  localparam int SR_VPP_ERR = 3;
  localparam logic [3:0] BOOT_BOT = 4'h0;  // addr[17:14] of a bottom boot block
  localparam logic [3:0] BOOT_TOP = 4'hF;  // addr[17:14] of a top boot block

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_CFG = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam int ST_BUSY = 0;
  localparam int ST_NEED_RA = 1;
  localparam int ST_LOCK_ERR = 2;
  localparam int ST_DEV_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operations written to CTRL[2:0]
  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_PROG = 3'h1, OP_ERASE = 3'h2,
    OP_STAT = 3'h3, OP_IDENT = 3'h4, OP_RACMD = 3'h5
  } bbfc_op_t;

  // CFG register, bit 0 upward: run, unlock_hv, boot_unlock, vpp_en, byte_n, top, id_hv
  typedef struct packed {
    logic id_hv;
    logic top;
    logic byte_n;
    logic vpp_en;
    logic boot_unlock;
    logic unlock_hv;
    logic run;
  } bbfc_cfg_t;
  localparam bbfc_cfg_t CFG_RST = 7'h01;

  // Flash strobe and data pins
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [17:0] addr;
    logic [15:0] dq_o;
    logic dq_oe;
  } bbfc_bus_t;
endpackage

// ---- hdl/bbfc_cyc.sv ----
// Purpose: One asynchronous flash bus cycle, write or read, per start pulse.
// Assumes: start only while idle; dq_i is asynchronous to aclk.
// Notes: Write cycles are write-strobe controlled; chip select rises after.
module bbfc_cyc (
  input wire logic aclk,                 // 20 MHz clock
  input wire logic aresetn,              // Synchronous reset, active low
  input wire logic start,                // Begin a cycle
  input wire logic wr,                   // 1 write, 0 read
  input wire logic [17:0] addr,          // Cycle address
  input wire logic [15:0] wdata,         // Write data
  input wire logic [15:0] dq_i,          // Flash data pins, input side
  output bbfc_pkg::bbfc_bus_t bus,       // Flash strobes and data out
  output logic done,                     // One-cycle pulse at cycle end
  output logic [15:0] rdata              // Sampled read data
);
  typedef enum logic [3:0] {
    P_IDLE = 4'b0001, P_ACT = 4'b0010, P_HOLD = 4'b0100, P_REC = 4'b1000
  } bbfc_ph_t;

  typedef struct packed {
    bbfc_ph_t ph;
    logic wr;
    logic [3:0] cnt;
    bbfc_pkg::bbfc_bus_t bus;
    logic done;
    logic [15:0] rdata;
    logic [15:0] sync1;
    logic [15:0] sync2;
  } bbfc_cyc_t;

  bbfc_cyc_t s_r, s_nxt;

  // ---------------------------------------------------------------
  // Cycle sequencer
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.sync1 = dq_i;
    s_nxt.sync2 = s_r.sync1;  // Second stage only; logic reads sync2
    case (s_r.ph)
      P_IDLE: begin
        if (start) begin
          s_nxt.ph = P_ACT;
          s_nxt.wr = wr;
          s_nxt.bus.addr = addr;
          s_nxt.bus.ce_n = 1'b0;
          s_nxt.bus.oe_n = wr;        // Output enable stays high on writes
          s_nxt.bus.we_n = ~wr;
          s_nxt.bus.dq_o = wdata;
          s_nxt.bus.dq_oe = wr;
          s_nxt.cnt = wr ? bbfc_pkg::WE_CYC : bbfc_pkg::ACC_CYC;
        end
      end
      P_ACT: begin
        s_nxt.cnt = s_r.cnt - 4'h1;
        if (s_r.cnt == 4'h1) begin
          // Write strobe rises first so the flash latches on it
          s_nxt.ph = s_r.wr ? P_HOLD : P_REC;
          s_nxt.bus.we_n = 1'b1;
          s_nxt.rdata = s_r.sync2;
          if (!s_r.wr) begin
            s_nxt.bus.ce_n = 1'b1;
            s_nxt.bus.oe_n = 1'b1;
          end
          s_nxt.cnt = bbfc_pkg::REC_CYC;
        end
      end
      P_HOLD: begin
        // Data held one cycle past the latching edge
        s_nxt.ph = P_REC;
        s_nxt.bus.ce_n = 1'b1;
        s_nxt.bus.dq_oe = 1'b0;
      end
      P_REC: begin
        s_nxt.cnt = s_r.cnt - 4'h1;
        if (s_r.cnt == 4'h1) begin
          s_nxt.ph = P_IDLE;
          s_nxt.done = 1'b1;
        end
      end
      default: s_nxt.ph = P_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.ph <= P_IDLE;
      s_r.bus.ce_n <= 1'b1;
      s_r.bus.oe_n <= 1'b1;
      s_r.bus.we_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus = s_r.bus;
  assign done = s_r.done;
  assign rdata = s_r.rdata;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_cmd_strobes: assert property (@(posedge aclk) disable iff (!aresetn)
    !s_r.bus.we_n |-> (s_r.bus.oe_n && !s_r.bus.ce_n && s_r.bus.dq_oe))
    else $error("write strobe low without chip select or driven data");
  a_we_first: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_r.bus.we_n) |-> !s_r.bus.ce_n ##1 s_r.bus.ce_n)
    else $error("chip select did not rise one cycle after write strobe");
  a_read_width: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(s_r.bus.oe_n) |-> (!s_r.bus.oe_n)[*5] ##1 s_r.bus.oe_n)
    else $error("read strobe width wrong");
endmodule

// ---- hdl/bbfc_ctrl.sv ----
// Purpose: Host controller for a sixteen-block boot-block flash on a parallel bus.
// Assumes: Software drives it over AXI4-Lite; one operation at a time.
// Notes: Boot protection is checked here before any bus cycle is made.
// Contract
// - Erase is setup code then confirm code, back to back.
// - Program is a write-setup code then the data cycle.
// - Read-array command must precede array reads after program or erase.
// - Reset pin low means deep power-down with outputs floating.
// - Command taken with output enable high, strobes low, first rising edge.
module bbfc_ctrl (
  input wire logic aclk,                  // 20 MHz clock
  input wire logic aresetn,               // Synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr,    // Write address
  input wire logic s_axi_awvalid,         // Write address valid
  output logic s_axi_awready,             // Write address ready
  input wire logic [31:0] s_axi_wdata,    // Write data
  input wire logic [3:0] s_axi_wstrb,     // Byte enables
  input wire logic s_axi_wvalid,          // Write data valid
  output logic s_axi_wready,              // Write data ready
  output logic [1:0] s_axi_bresp,         // Write response
  output logic s_axi_bvalid,              // Write response valid
  input wire logic s_axi_bready,          // Write response ready
  input wire logic [7:0] s_axi_araddr,    // Read address
  input wire logic s_axi_arvalid,         // Read address valid
  output logic s_axi_arready,             // Read address ready
  output logic [31:0] s_axi_rdata,        // Read data
  output logic [1:0] s_axi_rresp,         // Read response
  output logic s_axi_rvalid,              // Read data valid
  input wire logic s_axi_rready,          // Read data ready
  output logic [17:0] flash_addr,         // Flash address pins
  output logic [15:0] flash_dq_o,         // Flash data, output side
  output logic flash_dq_oe,               // Drive enable for data pins
  input wire logic [15:0] flash_dq_i,     // Flash data, input side
  output logic flash_ce_n,                // Chip select
  output logic flash_oe_n,                // Output enable
  output logic flash_we_n,                // Write strobe
  output logic reset_powerdown_n,         // Reset and power-down pin
  output logic rp_unlock_hv,              // Request unlock voltage on reset pin
  output logic boot_unlock,               // Boot-unlock pin
  output logic vpp_enable,                // Program supply switch
  output logic ident_high_voltage,        // Identify voltage on address pin
  output logic byte_n                     // Width select, 1 = word bus
);
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001, S_SOLO = 6'b000010, S_FIRST = 6'b000100,
    S_SECOND = 6'b001000, S_POLL = 6'b010000, S_READ = 6'b100000
  } bbfc_st_t;

  typedef struct packed {
    bbfc_st_t st;
    logic issued;
    logic cyc_go;
    logic cyc_wr;
    logic [15:0] cyc_data;
    bbfc_pkg::bbfc_op_t op;
    logic [17:0] addr;
    logic [15:0] wdata;
    bbfc_pkg::bbfc_cfg_t cfg;
    logic need_ra;
    logic lock_err;
    logic [7:0] dev_stat;
    logic [15:0] rd_data;
    logic [7:0] last_cmd;
    logic [7:0] prev_cmd;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } bbfc_ctl_t;

  bbfc_ctl_t s_r, s_nxt;
  bbfc_pkg::bbfc_bus_t bus;
  logic cyc_done;
  logic [15:0] cyc_rdata;

  // Byte-enable merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) old[i*8 +: 8] = nw[i*8 +: 8];
    end
    return old;
  endfunction

  // Protection check; boot block location follows the variant bit
  function automatic logic allowed(input logic [17:0] a, input bbfc_pkg::bbfc_cfg_t c);
    logic boot;
    boot = (a[17:14] == (c.top ? bbfc_pkg::BOOT_TOP : bbfc_pkg::BOOT_BOT));
    return c.vpp_en && (!boot || c.unlock_hv || c.boot_unlock);
  endfunction

  // ---------------------------------------------------------------
  // Register slave and operation sequencer
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    logic start;
    wv = '0;
    start = 1'b0;
    s_nxt = s_r;
    s_nxt.cyc_go = 1'b0;
    // Address and data channels taken in either order
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) s_nxt.bvalid = 1'b0;
    if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = bbfc_pkg::RESP_OKAY;
      case (s_r.aw_addr)
        bbfc_pkg::REG_CTRL: start = s_r.w_strb[0];
        bbfc_pkg::REG_ADDR: begin
          wv = merge({14'h0, s_r.addr}, s_r.w_data, s_r.w_strb);
          s_nxt.addr = wv[17:0];
        end
        bbfc_pkg::REG_WDATA: begin
          wv = merge({16'h0, s_r.wdata}, s_r.w_data, s_r.w_strb);
          s_nxt.wdata = wv[15:0];
        end
        bbfc_pkg::REG_CFG: if (s_r.w_strb[0]) s_nxt.cfg = s_r.w_data[6:0];
        bbfc_pkg::REG_STATUS: begin
          if (s_r.w_strb[0] && s_r.w_data[bbfc_pkg::ST_LOCK_ERR]) s_nxt.lock_err = 1'b0;
        end
        default: s_nxt.bresp = bbfc_pkg::RESP_SLVERR;
      endcase
    end
    s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_have && !s_nxt.bvalid;
    // Read channel, one outstanding read
    if (s_r.rvalid && s_axi_rready) s_nxt.rvalid = 1'b0;
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = bbfc_pkg::RESP_OKAY;
      case (s_axi_araddr)
        bbfc_pkg::REG_CTRL: s_nxt.rdata = {29'h0, s_r.op};
        bbfc_pkg::REG_ADDR: s_nxt.rdata = {14'h0, s_r.addr};
        bbfc_pkg::REG_WDATA: s_nxt.rdata = {16'h0, s_r.wdata};
        bbfc_pkg::REG_CFG: s_nxt.rdata = {25'h0, s_r.cfg};
        bbfc_pkg::REG_STATUS: s_nxt.rdata = {16'h0, s_r.dev_stat, 5'h0, s_r.lock_err,
                                            s_r.need_ra, s_r.st != S_IDLE};
        bbfc_pkg::REG_RDATA: s_nxt.rdata = {16'h0, s_r.rd_data};
        default: begin
          s_nxt.rdata = '0;
          s_nxt.rresp = bbfc_pkg::RESP_SLVERR;
        end
      endcase
    end
    s_nxt.arready = !s_nxt.rvalid;

    // Operation sequencer; a start while busy or powered down is dropped
    case (s_r.st)
      S_IDLE: begin
        if (start && s_r.cfg.run) begin
          s_nxt.op = bbfc_pkg::bbfc_op_t'(s_r.w_data[2:0]);
          s_nxt.issued = 1'b0;
          case (s_r.w_data[2:0])
            bbfc_pkg::OP_READ: s_nxt.st = s_r.need_ra ? S_SOLO : S_READ;
            bbfc_pkg::OP_STAT: s_nxt.st = S_READ;
            bbfc_pkg::OP_IDENT, bbfc_pkg::OP_RACMD: s_nxt.st = S_SOLO;
            bbfc_pkg::OP_PROG, bbfc_pkg::OP_ERASE: begin
              if (allowed(s_r.addr, s_r.cfg)) s_nxt.st = S_FIRST;
              else s_nxt.lock_err = 1'b1;
            end
            default: s_nxt.st = S_IDLE;
          endcase
        end
      end
      S_SOLO: begin
        // Single command: identify, or read-array alone or ahead of an array read
        s_nxt.cyc_wr = 1'b1;
        s_nxt.cyc_data = {8'h00, (s_r.op == bbfc_pkg::OP_IDENT) ?
                          bbfc_pkg::IDENTIFY_CMD : bbfc_pkg::CMD_READ_ARRAY};
        if (cyc_done) begin
          s_nxt.issued = 1'b0;
          s_nxt.need_ra = (s_r.op == bbfc_pkg::OP_IDENT);
          s_nxt.st = (s_r.op == bbfc_pkg::OP_RACMD) ? S_IDLE : S_READ;
        end
      end
      S_FIRST: begin
        s_nxt.cyc_wr = 1'b1;
        s_nxt.cyc_data = {8'h00, (s_r.op == bbfc_pkg::OP_ERASE) ?
                          bbfc_pkg::CMD_ERASE_SETUP : bbfc_pkg::CMD_WRITE_SETUP};
        if (cyc_done) begin
          s_nxt.issued = 1'b0;
          s_nxt.st = S_SECOND;
        end
      end
      S_SECOND: begin
        // Confirm or data follows its setup with no other cycle between
        s_nxt.cyc_wr = 1'b1;
        if (s_r.op == bbfc_pkg::OP_ERASE) s_nxt.cyc_data = {8'h00, bbfc_pkg::CMD_A};
        else s_nxt.cyc_data = s_r.cfg.byte_n ? s_r.wdata : {8'h00, s_r.wdata[7:0]};
        if (cyc_done) begin
          s_nxt.issued = 1'b0;
          s_nxt.need_ra = 1'b1;
          s_nxt.st = S_POLL;
        end
      end
      S_POLL: begin
        // Each poll is a fresh read cycle, so the status output refreshes
        s_nxt.cyc_wr = 1'b0;
        if (cyc_done) begin
          s_nxt.issued = 1'b0;
          s_nxt.dev_stat = cyc_rdata[7:0];
          if (cyc_rdata[bbfc_pkg::SR_READY]) s_nxt.st = S_IDLE;
        end
      end
      S_READ: begin
        s_nxt.cyc_wr = 1'b0;
        if (cyc_done) begin
          s_nxt.issued = 1'b0;
          s_nxt.rd_data = s_r.cfg.byte_n ? cyc_rdata : {8'h00, cyc_rdata[7:0]};
          if (s_r.op == bbfc_pkg::OP_STAT) s_nxt.dev_stat = cyc_rdata[7:0];
          s_nxt.st = S_IDLE;
        end
      end
      default: s_nxt.st = S_IDLE;
    endcase
    if (s_r.st != S_IDLE && !s_r.issued && !cyc_done) begin
      s_nxt.issued = 1'b1;
      s_nxt.cyc_go = 1'b1;
      if (s_nxt.cyc_wr) begin
        s_nxt.prev_cmd = s_r.last_cmd;
        s_nxt.last_cmd = s_nxt.cyc_data[7:0];
      end
    end
    // Power-down clears our copy of the status and the read-path state
    if (!s_r.cfg.run) begin
      s_nxt.need_ra = 1'b0;
      s_nxt.dev_stat = '0;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.st <= S_IDLE;
      s_r.op <= bbfc_pkg::OP_READ;
      s_r.cfg <= bbfc_pkg::CFG_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Flash bus cycle engine
  bbfc_cyc u_cyc (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(s_r.cyc_go),
    .wr(s_r.cyc_wr),
    .addr(s_r.addr),
    .wdata(s_r.cyc_data),
    .dq_i(flash_dq_i),
    .bus(bus),
    .done(cyc_done),
    .rdata(cyc_rdata)
  );

  // Pin and bus outputs, all from flip-flops
  assign flash_addr = bus.addr;
  assign flash_dq_o = bus.dq_o;
  assign flash_dq_oe = bus.dq_oe;
  assign flash_ce_n = bus.ce_n;
  assign flash_oe_n = bus.oe_n;
  assign flash_we_n = bus.we_n;
  assign reset_powerdown_n = s_r.cfg.run;
  assign rp_unlock_hv = s_r.cfg.unlock_hv;
  assign boot_unlock = s_r.cfg.boot_unlock;
  assign vpp_enable = s_r.cfg.vpp_en;
  assign ident_high_voltage = s_r.cfg.id_hv;
  assign byte_n = s_r.cfg.byte_n;
  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rvalid = s_r.rvalid;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_erase_pair: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_r.cyc_go && s_r.st == S_SECOND && s_r.op == bbfc_pkg::OP_ERASE) |->
    (s_r.prev_cmd == bbfc_pkg::CMD_ERASE_SETUP && s_r.last_cmd == bbfc_pkg::CMD_A))
    else $error("cmd_a not preceded by erase setup");
  a_prog_pair: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_r.cyc_go && s_r.st == S_SECOND && s_r.op == bbfc_pkg::OP_PROG) |->
    s_r.prev_cmd == bbfc_pkg::CMD_WRITE_SETUP)
    else $error("program data not preceded by write setup");
  a_array_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_r.cyc_go && s_r.st == S_READ && s_r.op == bbfc_pkg::OP_READ) |-> !s_r.need_ra)
    else $error("array read issued without read-array command");
  a_boot_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_r.lock_err) |-> s_r.st == S_IDLE ##1 !s_r.cyc_go)
    else $error("locked operation produced a bus cycle");
  a_no_supply: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_r.st == S_FIRST && s_r.cyc_go) |-> s_r.cfg.vpp_en)
    else $error("program or erase started without program supply");
  a_pd_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    !s_r.cfg.run ##1 !s_r.cfg.run |-> (!s_r.need_ra && s_r.dev_stat == 8'h00))
    else $error("power-down did not clear status copy");
  a_poll_after: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_r.st == S_SECOND && cyc_done) |=> s_r.st == S_POLL ##1 (s_r.cyc_go && !s_r.cyc_wr))
    else $error("status poll did not follow launch");
  a_axi_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_r.aw_have && s_r.w_have && !s_r.bvalid) |=> s_r.bvalid && !s_r.awready)
    else $error("write response not raised after address and data");
endmodule

// ---- sim/bbfc_flash_model.sv ----
// Purpose: Behavioural flash device on the far side of the controller.
// Assumes: Write-strobe cycles; bottom boot variant; blocks by addr[17:14].
// Notes: Engine reports ready on the third status poll after a launch.
module bbfc_flash_model #(
  parameter logic [7:0] MFG_ID = 8'hA5, // Arbitrary code
  parameter logic [7:0] DEV_ID = 8'h5C // Arbitrary code
) (
  input wire logic rp_n, // Reset and power-down
  input wire logic ce_n, // Chip select
  input wire logic oe_n, // Output enable
  input wire logic we_n, // Write strobe
  input wire logic [17:0] addr, // Address
  input wire logic [15:0] din, // Data from host
  output logic [15:0] dout // Data to host
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [int];
  logic [7:0] sr = 8'h80;
  logic [1:0] mode = 2'h0;
  logic [1:0] pend = 2'h0;
  logic [15:0] q = 16'h0000;
  int cnt = 0;
  // Power-down clears status and read path
  always @(negedge rp_n) {sr, mode, pend} = {8'h80, 4'h0};
  // Commands latch on the rising write strobe; a busy engine takes none
  always @(posedge we_n) if (!ce_n && oe_n && rp_n && sr[7]) begin
    if (pend == 2'h2) begin
      mem[addr] = din;
      sr[7] = 1'b0;
      cnt = 2;
      mode = 2'h1;
    end else if (pend == 2'h1 && din[7:0] == 8'hD0) begin
      foreach (mem[i]) if (i[17:14] == addr[17:14]) mem[i] = 16'hFFFF;
      sr[7] = 1'b0;
      cnt = 2;
      mode = 2'h1;
    end else if (din[7:0] == 8'hFF) mode = 2'h0;
    else if (din[7:0] == 8'h90) mode = 2'h2;
    pend = pend != 2'h0 ? 2'h0 : din[7:0] == 8'h20 ? 2'h1 :
      (din[7:0] == 8'h40 || din[7:0] == 8'h10) ? 2'h2 : 2'h0;
  end
  // Latched after the later falling strobe; settle lets both land
  always @(negedge oe_n or negedge ce_n) #1 if (!ce_n && !oe_n) begin
    if (mode == 2'h1 && cnt > 0) cnt--;
    else if (mode == 2'h1) sr[7] = 1'b1;
    q = mode == 2'h0 ? (mem.exists(addr) ? mem[addr] : 16'hFFFF) :
      {8'h00, mode == 2'h1 ? sr : addr[0] ? DEV_ID : MFG_ID};
  end
  // Released bus shows the inverse, never stale data
  assign dout = (!ce_n && !oe_n && rp_n) ? q : ~q;
endmodule

// ---- sim/test_boot_block_flash_command_control.sv ----
// Purpose: Self-checking bench for the boot-block flash controller.
// Assumes: Bottom boot model; 20 MHz clock; AXI answer ready held high.
// Notes: Expected ids come from the bench's own arbitrary codes.
module test_boot_block_flash_command_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] MFG = 8'h3C; // Arbitrary code
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, st, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, br;
  logic [17:0] flash_addr;
  logic [15:0] flash_dq_o, flash_dq_i, mdq;
  logic flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, reset_powerdown_n, rp_unlock_hv;
  logic boot_unlock, vpp_enable, ident_high_voltage, byte_n;
  int error_cnt = 0, total_checks = 0;
  // Shared data wire resolved from the drive enable
  assign flash_dq_i = flash_dq_oe ? flash_dq_o : mdq;
  bbfc_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .flash_addr, .flash_dq_o, .flash_dq_oe, .flash_dq_i,
    .flash_ce_n, .flash_oe_n, .flash_we_n, .reset_powerdown_n, .rp_unlock_hv, .boot_unlock,
    .vpp_enable, .ident_high_voltage, .byte_n);
  bbfc_flash_model #(.MFG_ID(MFG), .DEV_ID(8'h5C)) u_mem (.rp_n(reset_powerdown_n),
    .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .addr(flash_addr),
    .din(flash_dq_i), .dout(mdq));
  initial forever #25 aclk = ~aclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
  endtask
  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
  endtask
  // One flash operation, then poll until the controller is idle
  task automatic op(input logic [2:0] o, input logic [17:0] a, input logic [15:0] v);
    axw(bbfc_pkg::REG_ADDR, 32'(a));
    axw(bbfc_pkg::REG_WDATA, 32'(v));
    axw(bbfc_pkg::REG_CTRL, 32'(o));
    do begin
      axr(bbfc_pkg::REG_STATUS);
      st = d;
    end while (st[0] !== 1'b0);
  endtask
  task automatic rda(input logic [17:0] a);
    op(3'h0, a, 16'h0000);
    axr(bbfc_pkg::REG_RDATA);
  endtask
  task automatic t_prog();
    axw(bbfc_pkg::REG_CFG, 32'h19);
    op(3'h1, 18'h04000, 16'h1234);
    chk(32'({st[15], st[1]}), 32'h3);
    rda(18'h04000);
    chk(d, 32'h1234);
    op(3'h1, 18'h08000, 16'h5A5A);
    op(3'h2, 18'h04000, 16'h0000);
    rda(18'h04000);
    chk(d, 32'hFFFF);
    rda(18'h08000);
    chk(d, 32'h5A5A);
    $display("program and erase done");
  endtask
  task automatic t_lock();
    op(3'h1, 18'h00010, 16'h0F0F);
    chk(32'(st[2]), 32'h1);
    axw(bbfc_pkg::REG_STATUS, 32'h4);
    rda(18'h00010);
    chk(d, 32'hFFFF);
    axw(bbfc_pkg::REG_CFG, 32'h1D);
    op(3'h1, 18'h00010, 16'h0F0F);
    rda(18'h00010);
    chk(d, 32'h0F0F);
    axw(bbfc_pkg::REG_CFG, 32'h39);
    op(3'h1, 18'h3C000, 16'h0001);
    chk(32'(st[2]), 32'h1);
    axw(bbfc_pkg::REG_STATUS, 32'h4);
    axw(bbfc_pkg::REG_CFG, 32'h11);
    op(3'h1, 18'h08004, 16'h0001);
    chk(32'(st[2]), 32'h1);
    $display("protection done");
  endtask
  // Unlock voltage, byte bus, status read and lone read-array command
  task automatic t_mode();
    axw(bbfc_pkg::REG_STATUS, 32'h4);
    axw(bbfc_pkg::REG_CFG, 32'h0B);
    chk(32'({ident_high_voltage, byte_n, vpp_enable, boot_unlock, rp_unlock_hv,
      reset_powerdown_n}), 32'h0B);
    op(3'h1, 18'h00020, 16'hABCD);
    chk(32'(st[2]), 32'h0);
    op(3'h3, 18'h00020, 16'h0000);
    axr(bbfc_pkg::REG_RDATA);
    chk(d, 32'h80);
    op(3'h5, 18'h00020, 16'h0000);
    chk(32'(st[1]), 32'h0);
    rda(18'h08000);
    chk(d, 32'h5A);
    axw(bbfc_pkg::REG_CFG, 32'h19);
    rda(18'h00020);
    chk(d, 32'h00CD);
    axw(bbfc_pkg::REG_CFG, 32'h59);
    chk(32'({ident_high_voltage, byte_n, vpp_enable, boot_unlock, rp_unlock_hv,
      reset_powerdown_n}), 32'h39);
    $display("unlock and byte mode done");
  endtask
  task automatic t_misc();
    axw(bbfc_pkg::REG_CFG, 32'h19);
    op(3'h4, 18'h00000, 16'h0000);
    axr(bbfc_pkg::REG_RDATA);
    chk(d, {24'h0, MFG});
    axw(8'h40, 32'h1);
    chk(32'(br), 32'(bbfc_pkg::RESP_SLVERR));
    axw(bbfc_pkg::REG_CFG, 32'h18);
    chk(32'(reset_powerdown_n), 32'h0);
    axr(bbfc_pkg::REG_STATUS);
    chk(32'({d[15:8], d[1]}), 32'h0);
    $display("identify and power-down done");
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'({flash_ce_n, flash_oe_n, flash_we_n, reset_powerdown_n}), 32'hF);
    t_prog();
    t_lock();
    t_mode();
    t_misc();
    print_verdict();
  end
endmodule
